// file: src/ctu_edge_ctrl.sv
// Charge-time edge control: control register, edge 2 source qualification, status and IRQ.
// Assumes sources on pclk except pins and comparators, which are synchronised here.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps

module ctu_edge_ctrl import ctu_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sources and system state
   input wire ctu_src_t src,
   input wire logic idle_mode,
   // Block outputs
   output logic edge_one_out,
   output logic edge_two_out,
   output logic delay_gen_out,
   output logic discharge_out,
   output logic irq
);
   // =====================================================
   // Synchronisers for outside inputs
   logic [9:0] async_s1_q, async_s2_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         async_s1_q <= 10'h000;
         async_s2_q <= 10'h000;
      end else begin
         async_s1_q <= {src.cmp_out, src.pins};
         async_s2_q <= async_s1_q;
      end
   end
   wire [2:0] cmp_s = async_s2_q[9:7];
   wire [6:0] pin_s = async_s2_q[6:0];

   // =====================================================
   // APB decode
   logic [31:0] ctrl_q;
   logic [1:0] stat_q, ien_q;
   logic [31:0] rdata_q;
   logic rdy_q, err_q;
   wire acc = psel && penable && !rdy_q;
   wire hit_ctrl = paddr == CTU_CTRL_OFS;
   wire hit_stat = paddr == CTU_STAT_OFS;
   wire hit_ien = paddr == CTU_IEN_OFS;
   wire hit_iclr = paddr == CTU_ICLR_OFS;
   wire mapped = hit_ctrl || hit_stat || hit_ien || hit_iclr;
   wire wr_ctrl = acc && pwrite && hit_ctrl;
   wire wr_ien = acc && pwrite && hit_ien;
   wire wr_iclr = acc && pwrite && hit_iclr;
   wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                        hit_stat ? {30'h0, stat_q} :
                        hit_ien ? {30'h0, ien_q} : 32'h00000000;

   // =====================================================
   // Control fields
   wire on_b = ctrl_q[CTU_ON_BIT];
   wire sidl_b = ctrl_q[CTU_SIDL_BIT];
   wire run = on_b && !(sidl_b && idle_mode);
   wire gate = run && ctrl_q[CTU_EGATE_BIT];
   wire mode_edge = ctrl_q[CTU_E2MOD_BIT];
   wire pol = ctrl_q[CTU_E2POL_BIT];
   wire [3:0] sel = ctrl_q[CTU_E2SEL_LSB +: 4];

   // Source select
   function automatic logic pick(input logic [3:0] s, input logic [2:0] c, input logic [2:0] ic,
                                 input logic [6:0] p, input logic oc, input logic tm,
                                 input logic clk);
      case (s)
         4'hF: pick = c[2];
         4'hE: pick = c[1];
         4'hD: pick = c[0];
         4'hC: pick = clk;
         4'hB: pick = ic[2];
         4'hA: pick = ic[1];
         4'h9: pick = ic[0];
         4'h8: pick = p[6];
         4'h7: pick = p[5];
         4'h6: pick = p[4];
         4'h5: pick = p[3];
         4'h4: pick = p[2];
         4'h3: pick = p[0];
         4'h2: pick = p[1];
         4'h1: pick = oc;
         default: pick = tm;
      endcase
   endfunction

   // Bus clock as a source is a divide-by-two of pclk
   logic busclk_q, e2_prev_q;
   wire e2_raw = pick(sel, cmp_s, src.ic_evt, pin_s, src.ocmp_evt, src.tmr1_evt, busclk_q);
   wire e2_lvl = pol ? e2_raw : !e2_raw;
   wire e2_edge = pol ? (e2_raw && !e2_prev_q) : (!e2_raw && e2_prev_q);
   wire e2_hit = gate && (mode_edge ? e2_edge : e2_lvl);

   // Edge one event: edge pin one rising while running with the edge gate set (it shares the pin net)
   logic p1_prev_q;
   wire e1_hit = gate && pin_s[0] && !p1_prev_q;

   // =====================================================
   // Control register
   wire [31:0] ctrl_w = (pwdata & CTU_CTRL_WMASK) | (ctrl_q & ~CTU_CTRL_WMASK);
   logic [31:0] ctrl_d;
   always_comb begin
      ctrl_d = wr_ctrl ? ctrl_w : ctrl_q;
      if (e1_hit)
         ctrl_d[CTU_E1STAT_BIT] = 1'b1;
      if (e2_hit)
         ctrl_d[CTU_E2STAT_BIT] = 1'b1;
   end

   // Sticky interrupt status, set wins over clear
   wire [1:0] evt = {e2_hit, e1_hit};
   wire [1:0] stat_d = (stat_q & ~(wr_iclr ? pwdata[1:0] : 2'h0)) | evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= CTU_CTRL_RST;
         stat_q <= CTU_IRQ_RST;
         ien_q <= CTU_IRQ_RST;
         rdata_q <= 32'h00000000;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         busclk_q <= 1'b0;
         e2_prev_q <= 1'b0;
         p1_prev_q <= 1'b0;
         edge_one_out <= 1'b0;
         edge_two_out <= 1'b0;
         delay_gen_out <= 1'b0;
         discharge_out <= 1'b0;
         irq <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         if (wr_ien)
            ien_q <= pwdata[1:0];
         rdy_q <= acc;
         err_q <= acc && !mapped;
         if (acc && !pwrite)
            rdata_q <= rd_mux;
         busclk_q <= !busclk_q;
         e2_prev_q <= e2_raw;
         p1_prev_q <= pin_s[0];
         edge_one_out <= run && ctrl_q[CTU_E1STAT_BIT];
         edge_two_out <= run && ctrl_q[CTU_E2STAT_BIT];
         delay_gen_out <= run && ctrl_q[CTU_DGEN_BIT];
         discharge_out <= ctrl_q[CTU_IDIS_BIT];
         irq <= |(stat_d & ien_q);
      end
   end

   assign pready = rdy_q;
   assign pslverr = err_q;
   assign prdata = rdata_q;

   // =====================================================
   // Assertions
   property p_unimpl_zero;
      @(posedge pclk) disable iff (!presetn) ctrl_q[17:16] == 2'h0 && !ctrl_q[14];
   endproperty
   a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits set");

   property p_blocked;
      @(posedge pclk) disable iff (!presetn)
         (!ctrl_q[CTU_EGATE_BIT] && !wr_ctrl && !ctrl_q[CTU_E2STAT_BIT]) |=>
            !ctrl_q[CTU_E2STAT_BIT];
   endproperty
   a_blocked: assert property (p_blocked) else $error("edge passed while blocked");

   property p_off;
      @(posedge pclk) disable iff (!presetn) !on_b |=> !delay_gen_out && !edge_two_out;
   endproperty
   a_off: assert property (p_off) else $error("output while disabled");

   property p_idle;
      @(posedge pclk) disable iff (!presetn) (sidl_b && idle_mode) |=> !delay_gen_out;
   endproperty
   a_idle: assert property (p_idle) else $error("running in idle");

   property p_dgen;
      @(posedge pclk) disable iff (!presetn)
         (run && ctrl_q[CTU_DGEN_BIT]) |=> delay_gen_out;
   endproperty
   a_dgen: assert property (p_dgen) else $error("delay gen not driven");

   property p_sticky;
      @(posedge pclk) disable iff (!presetn)
         (ctrl_q[CTU_E2STAT_BIT] && !wr_ctrl) |=> ctrl_q[CTU_E2STAT_BIT];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status lost");

   property p_lvl;
      @(posedge pclk) disable iff (!presetn)
         (gate && !mode_edge && e2_lvl) |=> ctrl_q[CTU_E2STAT_BIT];
   endproperty
   a_lvl: assert property (p_lvl) else $error("level not caught");

   property p_edge_pol;
      @(posedge pclk) disable iff (!presetn)
         (gate && mode_edge && pol && e2_raw && !e2_prev_q) |=> ctrl_q[CTU_E2STAT_BIT];
   endproperty
   a_edge_pol: assert property (p_edge_pol) else $error("rising edge missed");

   property p_sel_c2;
      @(posedge pclk) disable iff (!presetn) (sel == CTU_SEL_C2) |-> e2_raw == cmp_s[1];
   endproperty
   a_sel_c2: assert property (p_sel_c2) else $error("wrong source");

   property p_sel_t1;
      @(posedge pclk) disable iff (!presetn) (sel == 4'h0) |-> e2_raw == src.tmr1_evt;
   endproperty
   a_sel_t1: assert property (p_sel_t1) else $error("wrong source");

   property p_e1;
      @(posedge pclk) disable iff (!presetn)
         e1_hit |=> ctrl_q[CTU_E1STAT_BIT] && stat_q[0] && (irq || !$past(ien_q[0]));
   endproperty
   a_e1: assert property (p_e1) else $error("edge one missed");

   property p_dis;
      @(posedge pclk) disable iff (!presetn) discharge_out == $past(ctrl_q[CTU_IDIS_BIT]);
   endproperty
   a_dis: assert property (p_dis) else $error("discharge not from its bit");

   property p_edge_fall;
      @(posedge pclk) disable iff (!presetn)
         (gate && mode_edge && !pol && !e2_raw && e2_prev_q) |=> ctrl_q[CTU_E2STAT_BIT];
   endproperty
   a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");

   property p_stat_e2;
      @(posedge pclk) disable iff (!presetn)
         e2_hit |=> stat_q[1];
   endproperty
   a_stat_e2: assert property (p_stat_e2) else $error("status two not set");

   property p_iclr;
      @(posedge pclk) disable iff (!presetn)
         (wr_iclr && pwdata[1] && !e2_hit) |=> !stat_q[1];
   endproperty
   a_iclr: assert property (p_iclr) else $error("status two not cleared");

   property p_stat_hold;
      @(posedge pclk) disable iff (!presetn)
         (stat_q[1] && !wr_iclr) |=> stat_q[1];
   endproperty
   a_stat_hold: assert property (p_stat_hold) else $error("status two lost");

   property p_irq_on;
      @(posedge pclk) disable iff (!presetn)
         ((|(stat_q & ien_q)) && !wr_iclr && !wr_ien) |=> irq;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("interrupt not raised");

   property p_sel_c3;
      @(posedge pclk) disable iff (!presetn)
         (sel == 4'hF) |-> e2_raw == cmp_s[2];
   endproperty
   a_sel_c3: assert property (p_sel_c3) else $error("wrong source");

   property p_sel_bus;
      @(posedge pclk) disable iff (!presetn)
         (sel == 4'hC) |-> e2_raw == busclk_q;
   endproperty
   a_sel_bus: assert property (p_sel_bus) else $error("wrong source");

   property p_sel_p13;
      @(posedge pclk) disable iff (!presetn)
         (sel == 4'h8) |-> e2_raw == pin_s[6];
   endproperty
   a_sel_p13: assert property (p_sel_p13) else $error("wrong source");

   property p_sel_pin1;
      @(posedge pclk) disable iff (!presetn)
         (sel == 4'h3) |-> e2_raw == pin_s[0];
   endproperty
   a_sel_pin1: assert property (p_sel_pin1) else $error("wrong source");

   property p_e1_sw;
      @(posedge pclk) disable iff (!presetn)
         (wr_ctrl && !e1_hit) |=> ctrl_q[CTU_E1STAT_BIT] == $past(pwdata[CTU_E1STAT_BIT]);
   endproperty
   a_e1_sw: assert property (p_e1_sw) else $error("edge one write lost");

   property p_e1_gate;
      @(posedge pclk) disable iff (!presetn)
         (!ctrl_q[CTU_EGATE_BIT] && !wr_ctrl && !ctrl_q[CTU_E1STAT_BIT]) |=>
            !ctrl_q[CTU_E1STAT_BIT];
   endproperty
   a_e1_gate: assert property (p_e1_gate) else $error("edge one passed while blocked");

   property p_halt;
      @(posedge pclk) disable iff (!presetn)
         (sidl_b && idle_mode && !wr_ctrl && !ctrl_q[CTU_E2STAT_BIT]) |=>
            !ctrl_q[CTU_E2STAT_BIT];
   endproperty
   a_halt: assert property (p_halt) else $error("edge caught in idle");

   c_e2: cover property (@(posedge pclk) disable iff (!presetn) e2_hit);
   c_lvl: cover property (@(posedge pclk) disable iff (!presetn) gate && !mode_edge && e2_lvl);
   c_e1: cover property (@(posedge pclk) disable iff (!presetn) e1_hit);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
   c_err: cover property (@(posedge pclk) disable iff (!presetn) err_q);
endmodule

// file: src/ctu_pkg.sv
// Package of the charge-time edge control block: register map, fields, reset values.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package ctu_pkg;
   localparam logic [11:0] CTU_CTRL_OFS = 12'h000;
   localparam logic [11:0] CTU_STAT_OFS = 12'h004;
   localparam logic [11:0] CTU_IEN_OFS = 12'h008;
   localparam logic [11:0] CTU_ICLR_OFS = 12'h00C;
   localparam int CTU_E1STAT_BIT = 24;
   localparam int CTU_E2STAT_BIT = 25;
   localparam int CTU_E2MOD_BIT = 23;
   localparam int CTU_E2POL_BIT = 22;
   localparam int CTU_E2SEL_LSB = 18;
   localparam int CTU_ON_BIT = 15;
   localparam int CTU_SIDL_BIT = 13;
   localparam int CTU_DGEN_BIT = 12;
   localparam int CTU_EGATE_BIT = 11;
   localparam int CTU_IDIS_BIT = 9;
   localparam logic [31:0] CTU_CTRL_WMASK = 32'h03FCBA00;
   localparam logic [31:0] CTU_CTRL_RST = 32'h00000000;
   localparam logic [1:0] CTU_IRQ_RST = 2'h0;
   localparam logic [3:0] CTU_SEL_C2 = 4'hE;

   typedef struct packed {
      logic [2:0] cmp_out;
      logic [2:0] ic_evt;
      logic ocmp_evt;
      logic tmr1_evt;
      logic [6:0] pins;
   } ctu_src_t;
endpackage

// file: tb/ctu_src_model.sv
// Far-side sources: comparators, captures, compare, timer and edge pins.
// Assumes the bench names one source code and a level to show on it.
`timescale 1ns/100ps
module ctu_src_model import ctu_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Source request
   input wire logic [3:0] which,
   input wire logic hold,
   // Sources
   output ctu_src_t src
);
   logic hold_q;
   logic [15:0] lv;
   logic [15:0] pu;
   // =====================
   // Level and event pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 1'b0;
      end else begin
         hold_q <= hold;
      end
   end
   assign lv = hold ? (16'h0001 << which) : 16'h0000;
   // Captures, compare and timer events last one cycle
   assign pu = lv & {16{~hold_q}};
   assign src = {lv[15:13], pu[11:9], pu[1], pu[0], lv[8:4], lv[2], lv[3]};
endmodule

// file: tb/tb_top.sv
// Self-checking bench of the charge-time edge control block.
// Assumes the APB slave answers with pready and sources come from ctu_src_model.
`timescale 1ns/100ps
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_errors++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top import ctu_pkg::*;;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, idle_mode, hold, err, irq;
   logic edge_one_out, edge_two_out, delay_gen_out, discharge_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [3:0] which, o;
   logic [7:0] tbl [8];
   ctu_src_t src;
   int n_errors, checks;
   // =====================
   // Design and far side
   ctu_edge_ctrl u_ctu_edge_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src(src), .idle_mode(idle_mode),
      .edge_one_out(edge_one_out), .edge_two_out(edge_two_out),
      .delay_gen_out(delay_gen_out), .discharge_out(discharge_out), .irq(irq));
   ctu_src_model u_ctu_src_model (.pclk(pclk), .presetn(presetn), .which(which),
      .hold(hold), .src(src));
   // =====================
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Entry: [7]on [6]halt_idle [4]edge_gate [3]sensitivity [2]polarity
   function automatic logic [31:0] ctl(input logic [7:0] t, input logic [3:0] sel);
      return {8'h00, t[3], t[2], sel, 2'h0, t[7], 1'b0, t[6], 1'b0, t[4], 11'h000};
   endfunction
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic fire(input logic [3:0] c);
      which <= c;
      hold <= 1'b1;
      repeat (5) @(posedge pclk);
      hold <= 1'b0;
      repeat (5) @(posedge pclk);
   endtask
   task automatic conclude();
      if (n_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // =====================
   // Clock, watchdog, sequence
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      conclude();
   end
   initial begin
      {psel, penable, pwrite, idle_mode, hold, paddr, pwdata, which} = '0;
      seed = 32'h00000E46;
      tbl = '{8'h1E, 8'h8E, 8'hFE, 8'hBF, 8'h91, 8'h94, 8'h98, 8'h9B};
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CTU_CTRL_OFS, 32'h0);
      `CHK("ctrl_rst", CTU_CTRL_RST, rd)
      apb(1'b1, CTU_CTRL_OFS, 32'hFCFBFFFF);
      apb(1'b0, CTU_CTRL_OFS, 32'h0);
      `CHK("ctrl_rd", 32'hFCFBFFFF & CTU_CTRL_WMASK, rd)
      `CHK("delay", 1'b1, delay_gen_out)
      `CHK("dis", 1'b1, discharge_out)
      apb(1'b1, CTU_IEN_OFS, 32'h2);
      for (int c = 0; c < 16; c++) begin
         o = 4'(xs());
         if (o == 4'(c) || o == 4'hC) o = (c == 5) ? 4'h6 : 4'h5;
         apb(1'b1, CTU_CTRL_OFS, ctl(8'h9E, 4'(c)));
         apb(1'b1, CTU_ICLR_OFS, 32'h3);
         if (c != 12) begin
            fire(o);
            apb(1'b0, CTU_STAT_OFS, 32'h0);
            `CHK("stray", 1'b0, rd[1])
         end
         fire(4'(c));
         apb(1'b0, CTU_STAT_OFS, 32'h0);
         `CHK("hit", 1'b1, rd[1])
      end
      foreach (tbl[i]) begin
         apb(1'b1, CTU_CTRL_OFS, ctl(tbl[i], 4'h4));
         // Again: a hit of the previous entry wins over the first write's clear
         apb(1'b1, CTU_CTRL_OFS, ctl(tbl[i], 4'h4));
         idle_mode <= tbl[i][5];
         apb(1'b1, CTU_ICLR_OFS, 32'h3);
         if (tbl[i][1]) fire(4'h4);
         else repeat (6) @(posedge pclk);
         apb(1'b0, CTU_STAT_OFS, 32'h0);
         `CHK("gate", tbl[i][0], rd[1])
         `CHK("e2out", tbl[i][0], edge_two_out)
         `CHK("irq", tbl[i][0], irq)
      end
      idle_mode <= 1'b0;
      apb(1'b1, CTU_IEN_OFS, 32'h0);
      apb(1'b0, CTU_STAT_OFS, 32'h0);
      `CHK("irq_mask", 1'b0, irq)
      apb(1'b1, CTU_IEN_OFS, 32'h3);
      apb(1'b1, CTU_ICLR_OFS, 32'h3);
      fire(4'h3);
      apb(1'b0, CTU_STAT_OFS, 32'h0);
      `CHK("e1_pin", 2'h1, rd[1:0])
      `CHK("irq_e1", 1'b1, irq)
      apb(1'b1, CTU_ICLR_OFS, 32'h1);
      apb(1'b1, CTU_CTRL_OFS, ctl(8'h9E, 4'h4));
      apb(1'b0, CTU_CTRL_OFS, 32'h0);
      `CHK("e1_clr", 1'b0, rd[24])
      `CHK("e1_out_clr", 1'b0, edge_one_out)
      apb(1'b1, CTU_CTRL_OFS, ctl(8'h9E, 4'h4) | 32'h01000000);
      apb(1'b0, CTU_CTRL_OFS, 32'h0);
      `CHK("e1_sw", 1'b1, rd[24])
      `CHK("e1_out", 1'b1, edge_one_out)
      `CHK("dis_off", 1'b0, discharge_out)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("unmap", 33'h100000000, {err, rd})
      conclude();
   end
endmodule
